//--- src/vcp_pkg.sv
// Package of constants and types for the video capture port.
package vcp_pkg;

    // ------------------------------------------------------------------
    // Register indices on the plain register port
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CAPTURE_CONFIG = 8'h50;
    localparam logic [7:0] ADDR_CAPTURE_CONTROL = 8'h51;
    localparam logic [7:0] ADDR_VSTART_LOW = 8'h52;
    localparam logic [7:0] ADDR_VSTART_HIGH = 8'h53;
    localparam logic [7:0] ADDR_LINES_LOW = 8'h57;
    localparam logic [7:0] ADDR_LINES_HIGH = 8'h58;
    localparam logic [7:0] ADDR_STATUS = 8'h59;
    localparam logic [7:0] ADDR_SERIAL_PROG = 8'h5a;
    localparam logic [7:0] ADDR_BASE_LOW = 8'h5b;
    localparam logic [7:0] ADDR_BASE_HIGH = 8'h5c;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CFG_RISING_EDGE_BIT = 0;
    localparam int CFG_NON_INTERLACED_BIT = 1;
    localparam int CFG_WIDTH_8_BIT = 2;
    localparam int CFG_COMPRESS_BIT = 3;
    localparam int CTL_ENABLE_BIT = 3;
    localparam int LINES_HIGH_BIT = 5;
    localparam int SP_CLOCK_CTL_BIT = 0;
    localparam int SP_DATA_CTL_BIT = 1;
    localparam int SP_CLOCK_STAT_BIT = 2;
    localparam int SP_DATA_STAT_BIT = 7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] SP_RESET = 8'h03;

    // ------------------------------------------------------------------
    // Timing figures
    // ------------------------------------------------------------------
    localparam int SOURCE_RATE_KHZ = 13500;
    localparam int MAX_PIXEL_CLOCK_KHZ = 20250;
    localparam int CORE_CLOCK_KHZ = 200000;
    localparam int MIN_CORE_PER_HALF =
        CORE_CLOCK_KHZ / (2 * MAX_PIXEL_CLOCK_KHZ);

    typedef enum logic [3:0] {
        VCP_IDLE = 4'b0001,
        VCP_WAIT_VS = 4'b0010,
        VCP_SKIP = 4'b0100,
        VCP_CAPTURE = 4'b1000
    } vcp_state_t;

    typedef struct packed {
        logic pixel_clock;
        logic vsync;
        logic line_ref;
        logic valid;
        logic [7:0] luma;
        logic [7:0] chroma;
    } vcp_pins_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] data;
        logic compressed;
    } vcp_mem_write_t;

endpackage

//--- src/vcp_capture_port.sv
// Video capture port receiver: pin sampling, window control, memory writes.
// Function
// - Pixels are taken at the source rate, independent of display read rate.
// - Pixels go to the video region of memory, raw or compressed.
// - Port width selects 8 or 16 bits per transfer.
// - Pixels are taken only while the valid qualifier is high, except in 16-bit mode two.
// - Vertical start offset counts from the trailing edge of vertical sync.
// - Nine-bit line count sets scanlines captured per field.
// - Nine-bit count skips that many line references before capture starts.
// - No horizontal window; each qualified sampling edge takes a pixel until LINE_WORDS words fill the line.
// - In 8-bit mode luma and chroma alternate on the luma bus.
// - In 16-bit mode, mode one samples on the falling edge using the valid qualifier.
// - In 16-bit mode, mode two samples on the rising edge, ignoring the valid qualifier.
// - Both modes take interlaced or non-interlaced fields.
// - Non-interlaced input writes addresses line after line.
// - A configuration register picks edge and interlace before enabling.
// - Capture starts only when the enable bit is written with one.
// - A two-wire open-drain serial programming channel is provided.
`timescale 1ns/100ps
`default_nettype none
module vcp_capture_port
    import vcp_pkg::*;
#(
    parameter int LINE_WORDS = 1024
)
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire vcp_pins_t pins_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    output vcp_mem_write_t mem_write_o,
    output logic mem_valid_o,
    output logic serial_prog_clock_oe_o,
    output logic serial_prog_data_oe_o,
    output logic serial_prog_clock_o,
    output logic serial_prog_data_o,
    input wire logic serial_prog_clock_i,
    input wire logic serial_prog_data_i,
    output logic field_odd_o
);

    // The column counter is 16 bits wide, so it cannot serve longer lines.
    if (LINE_WORDS < 2 || LINE_WORDS > 65535)
    begin : g_bad_line_words
        $error("LINE_WORDS out of range");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // The pixel clock is slower than a quarter of the core clock, so
    // sampling it as data finds every edge with margin.
    vcp_pins_t pins_meta_q, pins_sync_q, pins_last_q;
    logic [1:0] sp_meta_q, sp_sync_q;
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            pins_meta_q <= '0;
            pins_sync_q <= '0;
            pins_last_q <= '0;
            sp_meta_q <= 2'h3;
            sp_sync_q <= 2'h3;
        end
        else
        begin
            pins_meta_q <= pins_i;
            pins_sync_q <= pins_meta_q;
            pins_last_q <= pins_sync_q;
            sp_meta_q <= {serial_prog_data_i, serial_prog_clock_i};
            sp_sync_q <= sp_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] config_q, control_q, vstart_low_q, vstart_high_q;
    logic [7:0] lines_low_q, lines_high_q, sp_q, base_low_q, base_high_q;
    vcp_state_t state_q;
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            config_q <= REG_RESET;
            control_q <= REG_RESET;
            vstart_low_q <= REG_RESET;
            vstart_high_q <= REG_RESET;
            lines_low_q <= REG_RESET;
            lines_high_q <= REG_RESET;
            sp_q <= SP_RESET;
            base_low_q <= REG_RESET;
            base_high_q <= REG_RESET;
        end
        else if (reg_write_i)
        begin
            case (reg_addr_i)
                ADDR_CAPTURE_CONFIG: config_q <= reg_wdata_i;
                ADDR_CAPTURE_CONTROL: control_q <= reg_wdata_i;
                ADDR_VSTART_LOW: vstart_low_q <= reg_wdata_i;
                ADDR_VSTART_HIGH: vstart_high_q <= reg_wdata_i;
                ADDR_LINES_LOW: lines_low_q <= reg_wdata_i;
                ADDR_LINES_HIGH: lines_high_q <= reg_wdata_i;
                ADDR_SERIAL_PROG: sp_q <= reg_wdata_i;
                ADDR_BASE_LOW: base_low_q <= reg_wdata_i;
                ADDR_BASE_HIGH: base_high_q <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i || !reg_read_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else
        begin
            case (reg_addr_i)
                ADDR_CAPTURE_CONFIG: reg_rdata_o <= config_q;
                ADDR_CAPTURE_CONTROL: reg_rdata_o <= control_q;
                ADDR_VSTART_LOW: reg_rdata_o <= vstart_low_q;
                ADDR_VSTART_HIGH: reg_rdata_o <= {7'h00, vstart_high_q[0]};
                ADDR_LINES_LOW: reg_rdata_o <= lines_low_q;
                ADDR_LINES_HIGH: reg_rdata_o <= lines_high_q;
                ADDR_STATUS: reg_rdata_o <= {3'h0, field_odd_o, state_q};
                ADDR_SERIAL_PROG: reg_rdata_o <=
                    {sp_sync_q[1], 4'h0, sp_sync_q[0], sp_q[1:0]};
                ADDR_BASE_LOW: reg_rdata_o <= base_low_q;
                ADDR_BASE_HIGH: reg_rdata_o <= base_high_q;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Open-drain pins: the enable is high only while pulling low.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            serial_prog_clock_oe_o <= 1'b0;
            serial_prog_data_oe_o <= 1'b0;
            serial_prog_clock_o <= 1'b0;
            serial_prog_data_o <= 1'b0;
        end
        else
        begin
            serial_prog_clock_oe_o <= ~sp_q[SP_CLOCK_CTL_BIT];
            serial_prog_data_oe_o <= ~sp_q[SP_DATA_CTL_BIT];
            serial_prog_clock_o <= 1'b0;
            serial_prog_data_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Edge detection and qualification
    // ------------------------------------------------------------------
    logic enable, rising_mode, width8, take;
    logic clk_rise, clk_fall, line_rise, vsync_fall;
    logic [8:0] lines_total, vstart;

    assign enable = control_q[CTL_ENABLE_BIT];
    assign rising_mode = config_q[CFG_RISING_EDGE_BIT];
    assign width8 = config_q[CFG_WIDTH_8_BIT];
    assign clk_rise = pins_sync_q.pixel_clock & ~pins_last_q.pixel_clock;
    assign clk_fall = ~pins_sync_q.pixel_clock & pins_last_q.pixel_clock;
    assign line_rise = pins_sync_q.line_ref & ~pins_last_q.line_ref;
    assign vsync_fall = ~pins_sync_q.vsync & pins_last_q.vsync;
    assign lines_total = {lines_high_q[LINES_HIGH_BIT], lines_low_q};
    assign vstart = {vstart_high_q[0], vstart_low_q};

    // 16-bit mode two ignores the qualifier; 8-bit mode uses both edges.
    always_comb
    begin
        if (width8)
        begin
            take = (clk_rise | clk_fall) & pins_last_q.valid;
        end
        else if (rising_mode)
        begin
            take = clk_rise;
        end
        else
        begin
            take = clk_fall & pins_last_q.valid;
        end
    end

    // ------------------------------------------------------------------
    // Vertical window state machine
    // ------------------------------------------------------------------
    logic [8:0] line_cnt_q;
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state_q <= VCP_IDLE;
            line_cnt_q <= 9'h000;
        end
        else
        begin
            case (state_q)
                VCP_IDLE:
                    if (enable)
                    begin
                        state_q <= VCP_WAIT_VS;
                    end
                VCP_WAIT_VS:
                    if (!enable)
                    begin
                        state_q <= VCP_IDLE;
                    end
                    else if (vsync_fall)
                    begin
                        state_q <= VCP_SKIP;
                        line_cnt_q <= 9'h000;
                    end
                VCP_SKIP:
                    if (!enable)
                    begin
                        state_q <= VCP_IDLE;
                    end
                    else if (line_cnt_q == vstart)
                    begin
                        state_q <= VCP_CAPTURE;
                        line_cnt_q <= 9'h000;
                    end
                    else if (line_rise)
                    begin
                        line_cnt_q <= line_cnt_q + 9'h001;
                    end
                VCP_CAPTURE:
                    if (!enable || line_cnt_q == lines_total)
                    begin
                        state_q <= enable ? VCP_WAIT_VS : VCP_IDLE;
                    end
                    else if (line_rise)
                    begin
                        line_cnt_q <= line_cnt_q + 9'h001;
                    end
                default: state_q <= VCP_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pixel assembly and address generation
    // ------------------------------------------------------------------
    // Interlaced fields interleave lines; field parity flips each vsync.
    logic half_q, line_started_q;
    logic [7:0] luma_hold_q;
    logic [15:0] col_q, row_q;
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            field_odd_o <= 1'b0;
        end
        else if (vsync_fall)
        begin
            field_odd_o <= ~config_q[CFG_NON_INTERLACED_BIT] & ~field_odd_o;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            half_q <= 1'b0;
            luma_hold_q <= 8'h00;
            col_q <= 16'h0000;
            row_q <= 16'h0000;
            line_started_q <= 1'b0;
            mem_valid_o <= 1'b0;
            mem_write_o <= '0;
        end
        else
        begin
            mem_valid_o <= 1'b0;
            if (state_q != VCP_CAPTURE)
            begin
                half_q <= 1'b0;
                col_q <= 16'h0000;
                row_q <= 16'h0000;
                line_started_q <= 1'b0;
            end
            else if (line_rise)
            begin
                half_q <= 1'b0;
                col_q <= 16'h0000;
                if (line_started_q)
                begin
                    row_q <= row_q + (config_q[CFG_NON_INTERLACED_BIT]
                                      ? 16'h0001 : 16'h0002);
                end
            end
            else if (take && col_q < 16'(LINE_WORDS))
            begin
                line_started_q <= 1'b1;
                if (width8 && !half_q)
                begin
                    half_q <= 1'b1;
                    luma_hold_q <= pins_last_q.luma;
                end
                else
                begin
                    half_q <= 1'b0;
                    col_q <= col_q + 16'h0001;
                    mem_valid_o <= 1'b1;
                    mem_write_o.data <= width8
                        ? {luma_hold_q, pins_last_q.luma}
                        : {pins_last_q.luma, pins_last_q.chroma};
                    mem_write_o.compressed <= config_q[CFG_COMPRESS_BIT];
                    mem_write_o.addr <= {base_high_q, base_low_q, 8'h00}
                        + 24'(row_q + {15'h0000, field_odd_o
                              & ~config_q[CFG_NON_INTERLACED_BIT]})
                          * 24'(LINE_WORDS) + 24'(col_q);
                end
            end
        end
    end

endmodule
`default_nettype wire

//--- testbench/vcp_capture_assertions.sv
// Concurrent checks on the ports of the video capture port.
`timescale 1ns/100ps
`default_nettype none
module vcp_capture_assertions
    import vcp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire vcp_pins_t pins_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire vcp_mem_write_t mem_write_o,
    input wire logic mem_valid_o,
    input wire logic serial_prog_clock_oe_o,
    input wire logic serial_prog_data_oe_o,
    input wire logic serial_prog_clock_o,
    input wire logic serial_prog_data_o
);
    logic [7:0] cfg_q;
    logic [7:0] sp_q;
    logic en_q;

    // Shadow copies of the few register bits that the checks depend on.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            cfg_q <= REG_RESET;
            sp_q <= SP_RESET;
            en_q <= 1'b0;
        end
        else if (reg_write_i)
        begin
            if (reg_addr_i == ADDR_CAPTURE_CONFIG)
                cfg_q <= reg_wdata_i;
            if (reg_addr_i == ADDR_SERIAL_PROG)
                sp_q <= reg_wdata_i;
            if (reg_addr_i == ADDR_CAPTURE_CONTROL)
                en_q <= reg_wdata_i[CTL_ENABLE_BIT];
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    // The pins pass a two-stage sampler, so a write trails its pin edge by
    // two to three core cycles; a shorter window would miss slow designs.
    sequence s_fell_pin;
        $past(pins_i.pixel_clock, 6) && !$past(pins_i.pixel_clock, 2);
    endsequence
    sequence s_rose_pin;
        !$past(pins_i.pixel_clock, 6) && $past(pins_i.pixel_clock, 2);
    endsequence

    a_fall_edge_take: assert property (
        mem_valid_o && !cfg_q[CFG_RISING_EDGE_BIT]
        && !cfg_q[CFG_WIDTH_8_BIT] |-> s_fell_pin)
        else $error("write not after a falling pixel clock edge");
    a_rise_edge_take: assert property (
        mem_valid_o && cfg_q[CFG_RISING_EDGE_BIT] |-> s_rose_pin)
        else $error("write not after a rising pixel clock edge");
    a_write_single_pulse: assert property (
        mem_valid_o |=> !mem_valid_o [*3])
        else $error("memory write pulse too long");
    a_enable_gates_writes: assert property (
        !en_q |-> !mem_valid_o)
        else $error("memory write while capture disabled");
    a_compress_flag: assert property (
        mem_valid_o |-> mem_write_o.compressed == cfg_q[CFG_COMPRESS_BIT])
        else $error("compression flag differs from config");
    a_clock_pin_drive: assert property (
        $stable(sp_q[SP_CLOCK_CTL_BIT])
        |-> serial_prog_clock_oe_o == !sp_q[SP_CLOCK_CTL_BIT])
        else $error("serial clock enable differs from control");
    a_data_pin_drive: assert property (
        $stable(sp_q[SP_DATA_CTL_BIT])
        |-> serial_prog_data_oe_o == !sp_q[SP_DATA_CTL_BIT])
        else $error("serial data enable differs from control");
    a_open_drain_low: assert property (
        !serial_prog_clock_o && !serial_prog_data_o)
        else $error("open drain output not low");
endmodule
`default_nettype wire

//--- testbench/vcp_decoder_model.sv
// Behavioural model of the external video decoder driving the port pins.
`timescale 1ns/100ps
`default_nettype none
module vcp_decoder_model
    import vcp_pkg::*;
(
    input wire logic go_i,
    input wire logic byte_i,
    input wire logic rise_i,
    output logic busy_o,
    output vcp_pins_t pins_o
);
    // One 48 ns pixel; lines change midway between clock edges so that
    // neither sampling edge sees them move.
    task automatic pix(input logic lr, input logic vs, input logic [15:0] d);
        pins_o.line_ref = lr;
        pins_o.vsync = vs;
        pins_o.valid = lr & ~rise_i;
        pins_o.luma = d[15:8];
        pins_o.chroma = byte_i ? ~pins_o.chroma : d[7:0];
        #12 pins_o.pixel_clock = 1'b0;
        #12 if (byte_i) pins_o.luma = d[7:0];
        #12 pins_o.pixel_clock = 1'b1;
        #12;
    endtask

    // Vsync, then three lines of four pixels with four blank pixels each.
    task automatic frame();
        int ln;
        int c;
        busy_o = 1'b1;
        for (c = 0; c < 4; c++)
            pix(1'b0, 1'b1, ~{pins_o.luma, pins_o.chroma});
        for (ln = 0; ln < 3; ln++)
        begin
            for (c = 0; c < 4; c++)
                pix(1'b1, 1'b0, {8'(16 * ln + c), ~8'(16 * ln + c)});
            for (c = 0; c < 4; c++)
                pix(1'b0, 1'b0, ~{pins_o.luma, pins_o.chroma});
        end
        busy_o = 1'b0;
    endtask

    initial
    begin
        pins_o = '0;
        busy_o = 1'b0;
        #3;
        forever
        begin
            if (go_i === 1'b1)
                frame();
            else
                pix(1'b0, 1'b0, ~{pins_o.luma, pins_o.chroma});
        end
    end
endmodule
`default_nettype wire

//--- testbench/tb_video_capture_port.sv
// Self-checking bench for the video capture port.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) \
    begin \
        num_checks++; \
        if ((a) !== (e)) \
        begin \
            n_fail++; \
            $display("mismatch %s exp %0h got %0h", n, e, a); \
        end \
    end
module tb_video_capture_port
    import vcp_pkg::*;
;
    localparam int LW = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] ra = 8'h00;
    logic [7:0] wd = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic go = 1'b0;
    logic byte_m = 1'b0;
    logic rise_m = 1'b0;
    logic [7:0] rdata;
    logic mv, c_oe, d_oe, busy, fo;
    vcp_pins_t pins;
    vcp_mem_write_t mw;
    vcp_mem_write_t q[$];
    int n_fail = 0;
    int num_checks = 0;

    always #2.5 clk = ~clk;
    always @(negedge clk)
        if (mv === 1'b1)
            q.push_back(mw);

    vcp_decoder_model u_src (.go_i(go), .byte_i(byte_m), .rise_i(rise_m),
        .busy_o(busy), .pins_o(pins));
    // The serial pins have pull-ups, so a pin is low only while driven.
    vcp_capture_port #(.LINE_WORDS(LW)) dut (.core_clk_i(clk), .reset_i(rst),
        .pins_i(pins), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_write_i(we),
        .reg_read_i(re), .reg_rdata_o(rdata), .mem_write_o(mw),
        .mem_valid_o(mv), .serial_prog_clock_oe_o(c_oe),
        .serial_prog_data_oe_o(d_oe), .serial_prog_clock_o(),
        .serial_prog_data_o(), .serial_prog_clock_i(!c_oe),
        .serial_prog_data_i(!d_oe), .field_odd_o(fo));

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        ra <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(negedge clk);
        `CHK("rdata", e, rdata)
    endtask

    task automatic run_frame();
        int i;
        go <= 1'b1;
        for (i = 0; i < 50 && busy !== 1'b1; i++)
            @(posedge clk);
        `CHK("frame start", 1'b1, busy)
        go <= 1'b0;
        for (i = 0; i < 600 && busy !== 1'b0; i++)
            @(posedge clk);
        `CHK("frame end", 1'b0, busy)
        repeat (8) @(posedge clk);
    endtask

    // Skip one line reference after vsync, then take two lines of four.
    // The base bytes land at address bits 15:8 (low) and 23:16 (high).
    task automatic cap(input logic [7:0] cfg, input logic on);
        int k;
        int row;
        logic ni;
        logic [7:0] v;
        logic [23:0] exp_addr;
        ni = cfg[CFG_NON_INTERLACED_BIT];
        byte_m <= cfg[CFG_WIDTH_8_BIT];
        rise_m <= cfg[CFG_RISING_EDGE_BIT];
        wr(ADDR_CAPTURE_CONFIG, cfg);
        wr(ADDR_VSTART_LOW, 8'h01);
        wr(ADDR_VSTART_HIGH, 8'h00);
        wr(ADDR_LINES_LOW, 8'h02);
        wr(ADDR_LINES_HIGH, 8'h00);
        wr(ADDR_BASE_LOW, 8'h12);
        wr(ADDR_BASE_HIGH, 8'h34);
        wr(ADDR_CAPTURE_CONTROL, {4'h0, on, 3'h0});
        q.delete();
        run_frame();
        wr(ADDR_CAPTURE_CONTROL, 8'h00);
        `CHK("count", on ? 8 : 0, q.size())
        `CHK("field", ~ni, fo)
        for (k = 0; k < q.size(); k++)
        begin
            // Interlaced rows step by two; the first field here is odd.
            row = ni ? k / 4 : 2 * (k / 4) + 1;
            v = 8'(16 * (k / 4 + 1) + k % 4);
            exp_addr = 24'h341200 + 24'(row * LW + k % 4);
            `CHK("data", {v, ~v}, q[k].data)
            `CHK("addr", exp_addr, q[k].addr)
            `CHK("cmp", cfg[CFG_COMPRESS_BIT], q[k].compressed)
        end
    endtask

    task automatic t_regs();
        rd(ADDR_CAPTURE_CONFIG, REG_RESET);
        rd(ADDR_CAPTURE_CONTROL, REG_RESET);
        rd(ADDR_STATUS, {4'h0, VCP_IDLE});
        rd(8'h7f, 8'h00);
        wr(ADDR_LINES_LOW, 8'ha5);
        wr(ADDR_LINES_HIGH, 8'h20);
        rd(ADDR_LINES_LOW, 8'ha5);
        rd(ADDR_LINES_HIGH, 8'h20);
    endtask

    task automatic t_serial();
        rd(ADDR_SERIAL_PROG, 8'h87);
        wr(ADDR_SERIAL_PROG, 8'h01);
        repeat (4) @(posedge clk);
        `CHK("data_oe", 1'b1, d_oe)
        rd(ADDR_SERIAL_PROG, 8'h05);
        wr(ADDR_SERIAL_PROG, SP_RESET);
    endtask

    task automatic t_mode1();
        cap(8'h0a, 1'b0);
        cap(8'h0a, 1'b1);
    endtask

    task automatic t_mode2();
        cap(8'h03, 1'b1);
    endtask

    task automatic t_byte();
        cap(8'h06, 1'b1);
    endtask

    task automatic t_interlaced();
        cap(8'h00, 1'b1);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Five frames of about 1.3 us plus register traffic fit well inside.
    initial
    begin
        #40000;
        n_fail++;
        give_verdict();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_serial();
        t_mode1();
        t_mode2();
        t_byte();
        t_interlaced();
        give_verdict();
    end
endmodule

bind vcp_capture_port vcp_capture_assertions u_chk (.core_clk_i, .reset_i,
    .pins_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .mem_write_o,
    .mem_valid_o, .serial_prog_clock_oe_o, .serial_prog_data_oe_o,
    .serial_prog_clock_o, .serial_prog_data_o);
`default_nettype wire
